// >>> rtl/msc_mission_status.sv
`timescale 1ns/1ps
`default_nettype none

module msc_mission_status
   import msc_pkg::*;
(
   // Clock and power-on reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Mission configuration and events
   input  wire logic        alarm_triggered_start,
   input  wire logic        logging_enabled,
   input  wire msc_events_t ev,
   input  wire msc_rtc_t    rtc_now,
   // Memory function port
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_wr,
   input  wire logic [7:0]  mem_wdata,
   output logic [7:0]       mem_rdata,
   // Status to sampling engine
   output logic             mission_active,
   output logic             log_erased_flag,
   output logic             awaiting_alarm_start,
   output logic             start_accepted,
   output logic             log_sample_enable,
   output logic             alarm_test_enable,
   output logic [23:0]      start_delay_minutes
);

   // ==========================================================
   // State
   // ==========================================================
   msc_state_t s;
   msc_state_t next_s;
   logic [7:0] status_byte;
   logic       wake_logs;

   always_comb
   begin
      status_byte             = STATUS_FIXED;
      status_byte[BIT_ACTIVE] = s.mission_active;
      status_byte[BIT_ERASED] = s.log_erased_flag;
      status_byte[BIT_AWAIT]  = s.awaiting_alarm_start;
   end

   // One count per wake-up regardless of how many channels it logs
   assign wake_logs = ev.sample_wake && s.phase == MSC_LOG;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      next_s          = s;
      next_s.start_ok = 1'b0;

      // Delay bytes: writes only while no mission runs
      if (mem_wr && !s.mission_active)
      begin
         unique case (mem_addr)
            ADDR_DELAY_LO:      next_s.start_delay[7:0]   = mem_wdata;
            16'(ADDR_DELAY_LO + 16'h0001):
               next_s.start_delay[15:8]  = mem_wdata;
            ADDR_DELAY_HI:      next_s.start_delay[23:16] = mem_wdata;
            default:            next_s.start_delay        = s.start_delay;
         endcase
      end

      unique case (s.phase)
         MSC_IDLE:
         begin
            if (ev.forced_conv)
               next_s.lifetime_count = s.lifetime_count + 24'h000001;
         end
         MSC_DELAY:
         begin
            if (s.delay_left == DELAY_RESET)
               next_s.phase = alarm_triggered_start ? MSC_AWAIT : MSC_LOG;
            else if (ev.minute_tick)
               next_s.delay_left = s.delay_left - 24'h000001;
         end
         MSC_AWAIT:
         begin
            if (ev.alarm_test)
               next_s.lifetime_count = s.lifetime_count + 24'h000001;
            // First logged sample follows on the next sample wake
            if (ev.alarm_test && ev.temp_alarm)
               next_s.phase = MSC_LOG;
         end
         MSC_LOG:
         begin
            if (wake_logs)
            begin
               next_s.mission_count  = s.mission_count + 24'h000001;
               next_s.lifetime_count = s.lifetime_count + 24'h000001;
               if (s.first_pending)
               begin
                  next_s.stamp         = rtc_now;
                  next_s.first_pending = 1'b0;
               end
            end
         end
      endcase

      // A temperature alarm ends the wait, in or out of a mission, unless a start in the same cycle sets it again
      if (ev.temp_alarm)
         next_s.awaiting_alarm_start = 1'b0;

      // Stop outranks start and clear in the same cycle
      if (ev.stop_mission)
      begin
         next_s.mission_active = 1'b0;
         next_s.phase          = MSC_IDLE;
      end
      else if (ev.start_mission && !s.mission_active && s.log_erased_flag
               && logging_enabled)
      begin
         next_s.start_ok        = 1'b1;
         next_s.mission_active  = 1'b1;
         next_s.log_erased_flag = 1'b0;
         next_s.first_pending   = 1'b1;
         next_s.delay_left      = s.start_delay;
         next_s.phase           = MSC_DELAY;
         if (alarm_triggered_start)
            next_s.awaiting_alarm_start = 1'b1;
      end
      else if (ev.clear_memory && !s.mission_active)
      begin
         // Awaiting bit intentionally untouched here
         next_s.stamp           = STAMP_RESET;
         next_s.mission_count   = COUNT_RESET;
         next_s.log_erased_flag = 1'b1;
      end

      // Read data registered for a clean data output
      unique case (1'b1)
         mem_addr == ADDR_STATUS:
            next_s.rd_data = status_byte;
         mem_addr >= ADDR_DELAY_LO && mem_addr <= ADDR_DELAY_HI:
            next_s.rd_data = s.start_delay[8*(mem_addr - ADDR_DELAY_LO) +: 8];
         mem_addr >= ADDR_STAMP_LO && mem_addr <= ADDR_STAMP_HI:
            next_s.rd_data = s.stamp[8*(mem_addr - ADDR_STAMP_LO) +: 8];
         mem_addr >= ADDR_MCOUNT_LO && mem_addr <= ADDR_MCOUNT_HI:
            next_s.rd_data = s.mission_count[8*(mem_addr - ADDR_MCOUNT_LO) +: 8];
         mem_addr >= ADDR_LCOUNT_LO && mem_addr <= ADDR_LCOUNT_HI:
            next_s.rd_data = s.lifetime_count[8*(mem_addr - ADDR_LCOUNT_LO) +: 8];
         mem_addr == ADDR_VARIANT:
            next_s.rd_data = VARIANT_ID;
         default:
            next_s.rd_data = 8'h00;
      endcase
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // Only power-on reset clears the lifetime count
         s                <= '0;
         s.phase          <= MSC_IDLE;
         s.start_delay    <= DELAY_RESET;
         s.lifetime_count <= COUNT_RESET;
      end
      else
         s <= next_s;
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign mem_rdata            = s.rd_data;
   assign mission_active       = s.mission_active;
   assign log_erased_flag      = s.log_erased_flag;
   assign awaiting_alarm_start = s.awaiting_alarm_start;
   assign start_accepted       = s.start_ok;
   assign log_sample_enable    = s.phase == MSC_LOG;
   assign alarm_test_enable    = s.phase == MSC_AWAIT;
   assign start_delay_minutes  = s.start_delay;

endmodule : msc_mission_status
`default_nettype wire

// >>> rtl/msc_pkg.sv
package msc_pkg;

   // ==========================================================
   // Register addresses (byte addresses in device memory map)
   // ==========================================================
   localparam logic [15:0] ADDR_STATUS     = 16'h0215;
   localparam logic [15:0] ADDR_DELAY_LO   = 16'h0216;
   localparam logic [15:0] ADDR_DELAY_HI   = 16'h0218;
   localparam logic [15:0] ADDR_STAMP_LO   = 16'h0219;
   localparam logic [15:0] ADDR_STAMP_HI   = 16'h021E;
   localparam logic [15:0] ADDR_MCOUNT_LO  = 16'h0220;
   localparam logic [15:0] ADDR_MCOUNT_HI  = 16'h0222;
   localparam logic [15:0] ADDR_LCOUNT_LO  = 16'h0223;
   localparam logic [15:0] ADDR_LCOUNT_HI  = 16'h0225;
   localparam logic [15:0] ADDR_VARIANT    = 16'h0226;

   // ==========================================================
   // General status field positions and fixed bits
   // ==========================================================
   localparam int          BIT_ACTIVE      = 1;
   localparam int          BIT_ERASED      = 3;
   localparam int          BIT_AWAIT       = 4;
   localparam logic [7:0]  STATUS_FIXED    = 8'hC0;

   // Arbitrary neutral variant code
   localparam logic [7:0]  VARIANT_ID      = 8'h5A;

   localparam logic [23:0] DELAY_RESET     = 24'h000000;
   localparam logic [23:0] COUNT_RESET     = 24'h000000;
   localparam logic [47:0] STAMP_RESET     = 48'h000000000000;

   // ==========================================================
   // Mission phases
   // ==========================================================
   typedef enum logic [1:0] {
      MSC_IDLE  = 2'b00,
      MSC_DELAY = 2'b01,
      MSC_AWAIT = 2'b10,
      MSC_LOG   = 2'b11
   } msc_phase_t;

   // Real-time clock value: packed BCD fields
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;   // bit 7 hundred_year_flag
      logic [7:0] date;
      logic [7:0] hours;   // bit 6 12/24 selector
      logic [7:0] minutes;
      logic [7:0] seconds;
   } msc_rtc_t;

   // Events from the sampling engine and command decoder
   typedef struct packed {
      logic clear_memory;
      logic start_mission;
      logic stop_mission;
      logic forced_conv;
      logic minute_tick;
      logic sample_wake;
      logic alarm_test;
      logic temp_alarm;
   } msc_events_t;

   // Whole block state
   typedef struct packed {
      msc_phase_t  phase;
      logic        mission_active;
      logic        log_erased_flag;
      logic        awaiting_alarm_start;
      logic        first_pending;
      logic [23:0] delay_left;
      logic [23:0] start_delay;
      logic [47:0] stamp;
      logic [23:0] mission_count;
      logic [23:0] lifetime_count;
      logic [7:0]  rd_data;
      logic        start_ok;
   } msc_state_t;

endpackage : msc_pkg

// >>> tb/msc_host.sv
`timescale 1ns/1ps
`default_nettype none
module msc_host
   import msc_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Memory function port
   input  wire logic [7:0]  mem_rdata,
   output logic [15:0]      mem_addr,
   output logic             mem_wr,
   output logic [7:0]       mem_wdata
);
   initial
   begin
      mem_addr = 16'h0000;
      mem_wr = 1'b0;
      mem_wdata = 8'h00;
   end
   // Read data is registered, so it is taken one edge after the address
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      mem_addr <= a;
      @(posedge clk);
      #1 d = mem_rdata;
   endtask : rd
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      mem_addr <= a;
      mem_wr <= 1'b1;
      mem_wdata <= d;
      @(posedge clk);
      mem_wr <= 1'b0;
   endtask : wr
endmodule : msc_host
`default_nettype wire

// >>> tb/msc_props.sv
`timescale 1ns/1ps
`default_nettype none
module msc_props
   import msc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        alarm_triggered_start,
   input  wire logic        logging_enabled,
   input  wire msc_events_t ev,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_wr,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mission_active,
   input  wire logic        log_erased_flag,
   input  wire logic        awaiting_alarm_start,
   input  wire logic        start_accepted,
   input  wire logic        alarm_test_enable,
   input  wire logic [23:0] start_delay_minutes
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic ok;
   assign ok = ev.start_mission && !ev.stop_mission && !mission_active
      && log_erased_flag && logging_enabled;
   status_fixed_a: assert property (mem_addr == ADDR_STATUS |=>
      (mem_rdata & 8'hE5) == 8'hC0) else $error("status fixed bits wrong");
   start_take_a: assert property (ok |=> start_accepted && mission_active
      && !log_erased_flag) else $error("start not taken");
   start_refuse_a: assert property (ev.start_mission && !log_erased_flag
      |=> !start_accepted) else $error("start taken without erase");
   clear_sets_a: assert property (ev.clear_memory && !mission_active
      && !ev.start_mission && !ev.stop_mission |=> log_erased_flag) else $error("erase flag");
   await_set_a: assert property (ok && alarm_triggered_start
      |=> awaiting_alarm_start) else $error("awaiting not set");
   await_hold_a: assert property (awaiting_alarm_start && !ev.temp_alarm
      |=> awaiting_alarm_start) else $error("awaiting lost");
   alarm_clear_a: assert property (ev.temp_alarm && !ev.start_mission
      |=> !awaiting_alarm_start) else $error("awaiting not cleared");
   delay_lock_a: assert property (mission_active && mem_wr
      |=> $stable(start_delay_minutes)) else $error("delay written in mission");
   stop_ends_a: assert property (ev.stop_mission |=> !mission_active)
      else $error("stop ignored");
   delay_wait_a: assert property (ok && start_delay_minutes != 24'h000000
      |=> !alarm_test_enable [*2]) else $error("alarm test before delay");
endmodule : msc_props
bind msc_mission_status msc_props chk_i (.*);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import msc_pkg::*;
   logic        clk, rst, alarm_triggered_start, logging_enabled, mem_wr;
   logic        mission_active, log_erased_flag, awaiting_alarm_start;
   logic        start_accepted, log_sample_enable, alarm_test_enable;
   msc_events_t ev;
   msc_rtc_t    rtc_now;
   logic [15:0] mem_addr;
   logic [7:0]  mem_wdata, mem_rdata;
   logic [23:0] start_delay_minutes;
   logic [47:0] v;
   int          num_errors, n_tests, cyc;
   msc_mission_status uut (.*);
   msc_host host (.*);
   // ==========
   // Helpers
   // ==========
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdn(input logic [15:0] a, input int n);
      logic [7:0] b;
      v = '0;
      for (int i = 0; i < n; i++)
      begin
         host.rd(16'(a + i), b);
         v[8*i +: 8] = b;
      end
   endtask : rdn
   task automatic pulse(input logic [7:0] m);
      @(posedge clk);
      ev <= msc_events_t'(m);
      @(posedge clk);
      ev <= '0;
      #1;
   endtask : pulse
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   // ==========
   // Scenarios
   // ==========
   task automatic t_regs;
      host.wr(ADDR_STATUS, 8'hFF);
      rdn(ADDR_STATUS, 1); chk(v, 48'hC0);
      rdn(ADDR_VARIANT, 1); chk(v, 48'(VARIANT_ID));
      rdn(16'h0230, 1); chk(v, 48'h0);
      rdn(ADDR_LCOUNT_LO, 3); chk(v, 48'h0);
      for (int i = 0; i < 3; i++)
         host.wr(16'(ADDR_DELAY_LO + i), 8'(i + 1));
      rdn(ADDR_DELAY_LO, 3); chk(v, 48'h030201);
      host.wr(ADDR_STAMP_LO, 8'h77);
      rdn(ADDR_STAMP_LO, 6); chk(v, 48'h0);
      for (int i = 0; i < 3; i++)
         host.wr(16'(ADDR_DELAY_LO + i), 8'h00);
   endtask : t_regs
   task automatic t_mission;
      pulse(8'h40); chk({start_accepted, mission_active}, 0);
      pulse(8'h80); chk(log_erased_flag, 1);
      pulse(8'h40); chk({start_accepted, mission_active, log_erased_flag}, 6);
      pulse(8'h04); chk(log_sample_enable, 1);
      rtc_now <= 48'h240101000000;
      pulse(8'h04);
      rdn(ADDR_STAMP_LO, 6); chk(v, 48'h249231235958);
      rdn(ADDR_MCOUNT_LO, 3); chk(v, 48'h2);
      rdn(ADDR_LCOUNT_LO, 3); chk(v, 48'h2);
      pulse(8'h20); chk({mission_active, log_sample_enable}, 0);
      pulse(8'h10);
      pulse(8'h80);
      rdn(ADDR_MCOUNT_LO, 3); chk(v, 48'h0);
      rdn(ADDR_STAMP_LO, 6); chk(v, 48'h0);
      rdn(ADDR_LCOUNT_LO, 3); chk(v, 48'h3);
   endtask : t_mission
   task automatic t_alarm;
      alarm_triggered_start <= 1'b1;
      host.wr(ADDR_DELAY_LO, 8'h02);
      pulse(8'h40); chk(awaiting_alarm_start, 1);
      host.wr(ADDR_DELAY_LO, 8'h09);
      rdn(ADDR_DELAY_LO, 3); chk(v, 48'h2);
      pulse(8'h08); chk(alarm_test_enable, 0);
      pulse(8'h08);
      for (int i = 0; i < 4 && alarm_test_enable !== 1'b1; i++)
         @(posedge clk) #1;
      chk(alarm_test_enable, 1);
      pulse(8'h02);
      rdn(ADDR_LCOUNT_LO, 3); chk(v, 48'h4);
      pulse(8'h20); chk(awaiting_alarm_start, 1);
      pulse(8'h80); chk(awaiting_alarm_start, 1);
      pulse(8'h11); chk(awaiting_alarm_start, 0);
      rdn(ADDR_LCOUNT_LO, 3); chk(v, 48'h5);
   endtask : t_alarm
   // ==========
   // Run
   // ==========
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Hang guard well above the roughly 150 cycles the run needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial
   begin
      rst = 1'b1;
      alarm_triggered_start = 1'b0;
      logging_enabled = 1'b1;
      ev = '0;
      rtc_now = 48'h249231235958;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_mission();
      t_alarm();
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
